// *** mvor_regs.sv ***
// Low register page of the hardware monitor: test, diode mode, temperatures, fan duty.
// Assumes the bus target engine hands over byte accesses as one-cycle strobes on CLK,
// and that measurement, filter and duty sources are logic on the same clock.
//
// Function
// - Bit 0 at 00h enables tree test
// - Scratch at 01h reads back written byte
// - 05h bits 0-3 select diode transistor mode
// - Zone 1/2 raw temps auto-updated, read-only
// - Zone 3 auto-updated, read-only; zone 4 host-loaded or from input eight
// - Absent or faulty diode reads 80h
// - Filtered registers hold smoothed zone temps
// - Smoothing adjusted by separate control register
// - 0Ah/0Bh report upper eight duty bits
// - Driven duty is maximum of bound sources
// - 0Ch bit 6 enables override duty output 1
// - 0Ch bit 7 is override LSB
// - Override ignores sources except full-scale force
// - 0Dh holds override duty bits 8:1
// - Status/control gives full-duty forcing control
`timescale 1ns/1ps
`default_nettype none
`include "mvor_params.svh"

module mvor_regs
    import mvor_pkg::*;
#(
    parameter int NSRC = 4
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register access from the bus target engine
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Measurement results; zone order is 1b, 2b, 1a, 2a
    input wire logic TEMP_UPDATE,
    input wire logic [`MVOR_ZONES*8-1:0] ZONE_RAW_TEMP,
    input wire logic [`MVOR_ZONES-1:0] ZONE_DIODE_FAULT,
    input wire logic [`MVOR_ZONES*8-1:0] ZONE_SMOOTHED_TEMP,
    input wire logic [7:0] ZONE3_TEMP,
    input wire logic ZONE4_FROM_AIN8,
    input wire logic [7:0] ANALOG_INPUT_EIGHT,
    // Smoothing control from its own register, passed to the filter
    input wire logic [7:0] SMOOTH_CTRL,
    output logic [7:0] FILTER_CTRL,
    // Fan duty sources and the full-scale force from status/control
    input wire logic [NSRC*9-1:0] FAN_OUT1_SRC_DUTY,
    input wire logic [NSRC-1:0] FAN_OUT1_SRC_BIND,
    input wire logic [NSRC*9-1:0] FAN_OUT2_SRC_DUTY,
    input wire logic [NSRC-1:0] FAN_OUT2_SRC_BIND,
    input wire logic FULL_DUTY_FORCE,
    // Controls and driven duties
    output logic TREE_TEST_ON,
    output logic [3:0] DIODE_TRANSISTOR_SEL,
    output logic [8:0] FAN_OUT1_DUTY,
    output logic [8:0] FAN_OUT2_DUTY
);

    mvor_byte_t tree_test_enable_q;
    mvor_byte_t bus_scratch_q;
    mvor_byte_t diode_transistor_select_q;
    mvor_byte_t fan_out1_override_low_q;
    mvor_byte_t fan_out1_override_high_q;
    mvor_byte_t zone3_internal_temp_q;
    mvor_byte_t zone4_external_temp_q;
    mvor_byte_t raw_temp_q [`MVOR_ZONES];
    mvor_byte_t smoothed_temp_q [`MVOR_ZONES];
    mvor_byte_t rdata_d;
    mvor_duty_t fan_out1_override_duty;
    logic fan_out1_fine_override_on;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = REG_WR && (REG_ADDR == ofs);
    endfunction : wr_hit

    // Writes keep only the defined bits, so reserved bits always read zero.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            tree_test_enable_q <= `MVOR_REG_RESET;
        end
        else if (wr_hit(`MVOR_OFS_TREE))
        begin
            tree_test_enable_q <= REG_WDATA & `MVOR_TREE_MASK;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            bus_scratch_q <= `MVOR_REG_RESET;
        end
        else if (wr_hit(`MVOR_OFS_SCRATCH))
        begin
            bus_scratch_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            diode_transistor_select_q <= `MVOR_REG_RESET;
        end
        else if (wr_hit(`MVOR_OFS_DIODE))
        begin
            diode_transistor_select_q <= REG_WDATA & `MVOR_DIODE_MASK;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            fan_out1_override_low_q <= `MVOR_REG_RESET;
            fan_out1_override_high_q <= `MVOR_REG_RESET;
        end
        else
        begin
            if (wr_hit(`MVOR_OFS_OVR1_LOW))
            begin
                fan_out1_override_low_q <= REG_WDATA & `MVOR_OVR_LOW_MASK;
            end
            if (wr_hit(`MVOR_OFS_OVR1_HIGH))
            begin
                fan_out1_override_high_q <= REG_WDATA;
            end
        end
    end

    // Values above full scale are not clamped; the host must keep to 100h or less.
    assign fan_out1_fine_override_on = fan_out1_override_low_q[`MVOR_OVR_ON_BIT];
    assign fan_out1_override_duty = {fan_out1_override_high_q, fan_out1_override_low_q[`MVOR_OVR_LSB_BIT]};

    // Zone 1/2 registers follow the measurement only; host writes never reach them.
    generate
        for (genvar z = 0; z < `MVOR_ZONES; z++)
        begin : g_zone
            always_ff @(posedge CLK)
            begin
                if (!RESET_N)
                begin
                    raw_temp_q[z] <= `MVOR_REG_RESET;
                    smoothed_temp_q[z] <= `MVOR_REG_RESET;
                end
                else if (TEMP_UPDATE)
                begin
                    raw_temp_q[z] <= ZONE_DIODE_FAULT[z] ? `MVOR_DIODE_FAULT_VAL
                                                         : ZONE_RAW_TEMP[z*8 +: 8];
                    smoothed_temp_q[z] <= ZONE_SMOOTHED_TEMP[z*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            zone3_internal_temp_q <= `MVOR_REG_RESET;
        end
        else if (TEMP_UPDATE)
        begin
            zone3_internal_temp_q <= ZONE3_TEMP;
        end
    end

    // While zone 4 follows analog input eight, host writes to it are dropped.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            zone4_external_temp_q <= `MVOR_REG_RESET;
        end
        else if (ZONE4_FROM_AIN8)
        begin
            if (TEMP_UPDATE)
            begin
                zone4_external_temp_q <= ANALOG_INPUT_EIGHT;
            end
        end
        else if (wr_hit(`MVOR_OFS_Z4))
        begin
            zone4_external_temp_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            FILTER_CTRL <= `MVOR_REG_RESET;
        end
        else
        begin
            FILTER_CTRL <= SMOOTH_CTRL;
        end
    end

    mvor_duty_resolve #(.NSRC(NSRC)) u_out1 (
        .clk(CLK),
        .reset_n(RESET_N),
        .src_duty(FAN_OUT1_SRC_DUTY),
        .src_bind(FAN_OUT1_SRC_BIND),
        .ovr_on(fan_out1_fine_override_on),
        .ovr_duty(fan_out1_override_duty),
        .force_full(FULL_DUTY_FORCE),
        .duty_q(FAN_OUT1_DUTY)
    );

    mvor_duty_resolve #(.NSRC(NSRC)) u_out2 (
        .clk(CLK),
        .reset_n(RESET_N),
        .src_duty(FAN_OUT2_SRC_DUTY),
        .src_bind(FAN_OUT2_SRC_BIND),
        .ovr_on(1'b0),
        .ovr_duty(`MVOR_DUTY_RESET),
        .force_full(FULL_DUTY_FORCE),
        .duty_q(FAN_OUT2_DUTY)
    );

    always_comb
    begin
        case (REG_ADDR)
            `MVOR_OFS_TREE: rdata_d = tree_test_enable_q;
            `MVOR_OFS_SCRATCH: rdata_d = bus_scratch_q;
            `MVOR_OFS_DIODE: rdata_d = diode_transistor_select_q;
            `MVOR_OFS_Z1B_RAW: rdata_d = raw_temp_q[0];
            `MVOR_OFS_Z2B_RAW: rdata_d = raw_temp_q[1];
            `MVOR_OFS_Z1B_SM: rdata_d = smoothed_temp_q[0];
            `MVOR_OFS_Z2B_SM: rdata_d = smoothed_temp_q[1];
            `MVOR_OFS_DUTY1: rdata_d = FAN_OUT1_DUTY[8:1];
            `MVOR_OFS_DUTY2: rdata_d = FAN_OUT2_DUTY[8:1];
            `MVOR_OFS_OVR1_LOW: rdata_d = fan_out1_override_low_q;
            `MVOR_OFS_OVR1_HIGH: rdata_d = fan_out1_override_high_q;
            `MVOR_OFS_Z1A_RAW: rdata_d = raw_temp_q[2];
            `MVOR_OFS_Z2A_RAW: rdata_d = raw_temp_q[3];
            `MVOR_OFS_Z3: rdata_d = zone3_internal_temp_q;
            `MVOR_OFS_Z4: rdata_d = zone4_external_temp_q;
            `MVOR_OFS_Z1A_SM: rdata_d = smoothed_temp_q[2];
            `MVOR_OFS_Z2A_SM: rdata_d = smoothed_temp_q[3];
            default: rdata_d = `MVOR_REG_RESET;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            REG_RDATA <= `MVOR_REG_RESET;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
            begin
                REG_RDATA <= rdata_d;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            TREE_TEST_ON <= 1'b0;
            DIODE_TRANSISTOR_SEL <= 4'h0;
        end
        else
        begin
            TREE_TEST_ON <= tree_test_enable_q[`MVOR_TREE_BIT];
            DIODE_TRANSISTOR_SEL <= diode_transistor_select_q[3:0];
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_tree_write;
        wr_hit(`MVOR_OFS_TREE);
    endsequence

    property p_tree;
        s_tree_write |=> ##1 TREE_TEST_ON == $past(REG_WDATA[`MVOR_TREE_BIT], 2);
    endproperty
    a_tree: assert property (p_tree) else $error("tree test output did not follow write");

    sequence s_scratch_write;
        wr_hit(`MVOR_OFS_SCRATCH);
    endsequence
    sequence s_scratch_read;
        REG_RD && REG_ADDR == `MVOR_OFS_SCRATCH && !REG_WR;
    endsequence

    property p_scratch;
        logic [7:0] v;
        (s_scratch_write, v = REG_WDATA) ##1 ((!wr_hit(`MVOR_OFS_SCRATCH)) throughout (##[0:7] s_scratch_read))
            |=> REG_RDATA == v;
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch did not read back");

    property p_diode;
        wr_hit(`MVOR_OFS_DIODE) |=> ##1 DIODE_TRANSISTOR_SEL == $past(REG_WDATA[3:0], 2);
    endproperty
    a_diode: assert property (p_diode) else $error("diode select did not follow write");

    property p_raw_ro;
        !TEMP_UPDATE |=> $stable(raw_temp_q[0]) && $stable(raw_temp_q[1]);
    endproperty
    a_raw_ro: assert property (p_raw_ro) else $error("raw temp changed without update");

    property p_fault;
        TEMP_UPDATE && ZONE_DIODE_FAULT[0] |=> raw_temp_q[0] == `MVOR_DIODE_FAULT_VAL;
    endproperty
    a_fault: assert property (p_fault) else $error("faulty diode did not read 80h");

    property p_smoothed;
        TEMP_UPDATE |=> smoothed_temp_q[2] == $past(ZONE_SMOOTHED_TEMP[23:16]);
    endproperty
    a_smoothed: assert property (p_smoothed) else $error("smoothed temp not captured");

    property p_zone4_sel;
        ZONE4_FROM_AIN8 && !TEMP_UPDATE |=> $stable(zone4_external_temp_q);
    endproperty
    a_zone4_sel: assert property (p_zone4_sel) else $error("zone 4 changed while bound to input eight");

    property p_readback;
        REG_RD && REG_ADDR == `MVOR_OFS_DUTY1 |=> REG_RVALID && REG_RDATA == $past(FAN_OUT1_DUTY[8:1]);
    endproperty
    a_readback: assert property (p_readback) else $error("duty readback wrong");

    property p_reserved;
        tree_test_enable_q[7:1] == 7'h00 && diode_transistor_select_q[7:4] == 4'h0
            && fan_out1_override_low_q[5:0] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_ovr_path;
        wr_hit(`MVOR_OFS_OVR1_LOW) && REG_WDATA[`MVOR_OVR_ON_BIT] && !FULL_DUTY_FORCE ##1 !FULL_DUTY_FORCE
            |=> FAN_OUT1_DUTY == {fan_out1_override_high_q, $past(REG_WDATA[`MVOR_OVR_LSB_BIT], 2)};
    endproperty
    a_ovr_path: assert property (p_ovr_path) else $error("override not driven on output 1");

endmodule : mvor_regs
`default_nettype wire

// *** mvor_params.svh ***
// Offsets, field positions, reset and fixed values of the monitor low register page.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MVOR_PARAMS_SVH
`define MVOR_PARAMS_SVH

`define MVOR_OFS_TREE 8'h00
`define MVOR_OFS_SCRATCH 8'h01
`define MVOR_OFS_DIODE 8'h05
`define MVOR_OFS_Z1B_RAW 8'h06
`define MVOR_OFS_Z2B_RAW 8'h07
`define MVOR_OFS_Z1B_SM 8'h08
`define MVOR_OFS_Z2B_SM 8'h09
`define MVOR_OFS_DUTY1 8'h0a
`define MVOR_OFS_DUTY2 8'h0b
`define MVOR_OFS_OVR1_LOW 8'h0c
`define MVOR_OFS_OVR1_HIGH 8'h0d
`define MVOR_OFS_Z1A_RAW 8'h50
`define MVOR_OFS_Z2A_RAW 8'h51
`define MVOR_OFS_Z3 8'h52
`define MVOR_OFS_Z4 8'h53
`define MVOR_OFS_Z1A_SM 8'h54
`define MVOR_OFS_Z2A_SM 8'h55

`define MVOR_REG_RESET 8'h00
`define MVOR_DIODE_FAULT_VAL 8'h80
`define MVOR_DUTY_FULL 9'h100
`define MVOR_DUTY_RESET 9'h000
`define MVOR_TREE_BIT 0
`define MVOR_OVR_ON_BIT 6
`define MVOR_OVR_LSB_BIT 7
`define MVOR_TREE_MASK 8'h01
`define MVOR_DIODE_MASK 8'h0f
`define MVOR_OVR_LOW_MASK 8'hc0
`define MVOR_ZONES 4

`endif

// *** mvor_pkg.sv ***
// Types shared by the monitor low register page and its duty resolver.
// Assumes the constants header is on the include path.
`default_nettype none
`include "mvor_params.svh"

package mvor_pkg;
    typedef logic [7:0] mvor_byte_t;
    typedef logic [8:0] mvor_duty_t;
endpackage : mvor_pkg
`default_nettype wire

// *** mvor_duty_resolve.sv ***
// Duty resolver for one fan output: max of bound sources, override, full-scale force.
// Assumes all inputs come from logic on CLK; the result is a registered 9-bit duty.
`timescale 1ns/1ps
`default_nettype none
`include "mvor_params.svh"

module mvor_duty_resolve
    import mvor_pkg::*;
#(
    parameter int NSRC = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Duty sources and their binding to this output
    input wire logic [NSRC*9-1:0] src_duty,
    input wire logic [NSRC-1:0] src_bind,
    // Override and full-scale force
    input wire logic ovr_on,
    input wire mvor_duty_t ovr_duty,
    input wire logic force_full,
    // Driven duty
    output mvor_duty_t duty_q
);

    mvor_duty_t max_d;
    mvor_duty_t duty_d;

    always_comb
    begin
        max_d = `MVOR_DUTY_RESET;
        for (int i = 0; i < NSRC; i++)
        begin
            if (src_bind[i] && (src_duty[i*9 +: 9] > max_d))
            begin
                max_d = src_duty[i*9 +: 9];
            end
        end
    end

    // Full-scale force beats the override; the override hides every bound source.
    always_comb
    begin
        if (force_full)
        begin
            duty_d = `MVOR_DUTY_FULL;
        end
        else if (ovr_on)
        begin
            duty_d = ovr_duty;
        end
        else
        begin
            duty_d = max_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            duty_q <= `MVOR_DUTY_RESET;
        end
        else
        begin
            duty_q <= duty_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_force_full;
        force_full |=> duty_q == `MVOR_DUTY_FULL;
    endproperty
    a_force_full: assert property (p_force_full) else $error("full force did not give full duty");

    property p_override;
        ovr_on && !force_full |=> duty_q == $past(ovr_duty);
    endproperty
    a_override: assert property (p_override) else $error("override duty not driven");

    generate
        for (genvar g = 0; g < NSRC; g++)
        begin : g_src
            property p_not_below;
                !ovr_on && !force_full && src_bind[g] |=> duty_q >= $past(src_duty[g*9 +: 9]);
            endproperty
            a_not_below: assert property (p_not_below) else $error("duty below a bound source");
        end
    endgenerate

endmodule : mvor_duty_resolve
`default_nettype wire

// *** mvor_host_model.sv ***
// Host side of the register strobe port: byte writes and reads as one-cycle strobes.
// Assumes the page answers a read with valid data exactly one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
`include "mvor_params.svh"

module mvor_host_model
    import mvor_pkg::*;
(
    // Clock
    input wire logic clk,
    // Strobe port toward the page
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    mvor_byte_t ovr_low = 8'h00;
    mvor_byte_t ovr_high = 8'h00;

    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released lines show the inverse so a stale value is never taken for a live one.
    task automatic wr(input mvor_byte_t addr, input mvor_byte_t data);
        mvor_duty_t duty;
        duty = (addr == `MVOR_OFS_OVR1_HIGH) ? {data, ovr_low[7]} :
               (addr == `MVOR_OFS_OVR1_LOW) ? {ovr_high, data[7]} : `MVOR_DUTY_RESET;
        if (duty > `MVOR_DUTY_FULL)
        begin
            $display("host model: override duty %h withheld", duty);
            return;
        end
        if (addr == `MVOR_OFS_OVR1_HIGH)
            ovr_high = data;
        if (addr == `MVOR_OFS_OVR1_LOW)
            ovr_low = data;
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~data;
        reg_addr = ~addr;
    endtask : wr

    task automatic rd(input mvor_byte_t addr, output mvor_byte_t data, output logic valid);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        valid = reg_rvalid;
        data = reg_rdata;
    endtask : rd
endmodule : mvor_host_model
`default_nettype wire

// *** monitor_value_override_regs_tb_top.sv ***
// Self-checking bench for the monitor low register page, driven through the host model.
// Assumes the page and its duty resolver are compiled with the shared package.
`timescale 1ns/1ps
`default_nettype none
`include "mvor_params.svh"

module monitor_value_override_regs_tb_top
    import mvor_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n, temp_update, zone4_from_ain8, full_duty_force;
    logic reg_wr, reg_rd, reg_rvalid, tree_test_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, zone3_temp, analog_input_eight, smooth_ctrl, filter_ctrl;
    logic [31:0] zone_raw_temp, zone_smoothed_temp;
    logic [3:0] zone_diode_fault, out1_bind, out2_bind, diode_sel;
    logic [35:0] out1_src, out2_src;
    logic [8:0] fan_out1_duty, fan_out2_duty;
    int fails = 0;
    int check_count = 0;
    mvor_byte_t rdat;
    logic rval;
    mvor_byte_t offs[18] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
                             8'h0c, 8'h0d, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h30};
    mvor_byte_t raw_ofs[4] = '{8'h06, 8'h07, 8'h50, 8'h51};
    mvor_byte_t sm_ofs[4] = '{8'h08, 8'h09, 8'h54, 8'h55};

    always #12.5 clk = ~clk;

    mvor_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    mvor_regs #(.NSRC(4)) dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .TEMP_UPDATE(temp_update), .ZONE_RAW_TEMP(zone_raw_temp), .ZONE_DIODE_FAULT(zone_diode_fault),
        .ZONE_SMOOTHED_TEMP(zone_smoothed_temp), .ZONE3_TEMP(zone3_temp), .ZONE4_FROM_AIN8(zone4_from_ain8),
        .ANALOG_INPUT_EIGHT(analog_input_eight), .SMOOTH_CTRL(smooth_ctrl), .FILTER_CTRL(filter_ctrl),
        .FAN_OUT1_SRC_DUTY(out1_src), .FAN_OUT1_SRC_BIND(out1_bind), .FAN_OUT2_SRC_DUTY(out2_src),
        .FAN_OUT2_SRC_BIND(out2_bind), .FULL_DUTY_FORCE(full_duty_force), .TREE_TEST_ON(tree_test_on),
        .DIODE_TRANSISTOR_SEL(diode_sel), .FAN_OUT1_DUTY(fan_out1_duty), .FAN_OUT2_DUTY(fan_out2_duty));

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rd(input mvor_byte_t addr, input mvor_byte_t exp);
        host.rd(addr, rdat, rval);
        chk("read valid", 9'h001, {8'h00, rval});
        chk($sformatf("register %h", addr), {1'b0, exp}, {1'b0, rdat});
    endtask : chk_rd

    // Control outputs follow a write two edges later, so two edges are let pass.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic pulse_temp();
        @(posedge clk);
        #1;
        temp_update = 1'b1;
        @(posedge clk);
        #1;
        temp_update = 1'b0;
    endtask : pulse_temp

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial
    begin
        reset_n = 1'b0;
        temp_update = 1'b0;
        zone4_from_ain8 = 1'b0;
        full_duty_force = 1'b0;
        zone_raw_temp = 32'h44332211;
        zone_smoothed_temp = 32'h88776655;
        zone_diode_fault = 4'h0;
        zone3_temp = 8'h29;
        analog_input_eight = 8'h77;
        smooth_ctrl = 8'h00;
        out1_src = {9'h0ff, 9'h0a3, 9'h1f0, 9'h040};
        out2_src = {9'h010, 9'h020, 9'h100, 9'h030};
        out1_bind = 4'h0;
        out2_bind = 4'h0;
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        foreach (offs[i])
            chk_rd(offs[i], 8'h00);
        chk("duty out1 after reset", 9'h000, fan_out1_duty);
        $display("test reset done");

        host.wr(`MVOR_OFS_TREE, 8'hff);
        settle();
        chk("tree output", 9'h001, {8'h00, tree_test_on});
        chk_rd(`MVOR_OFS_TREE, 8'h01);
        host.wr(`MVOR_OFS_TREE, 8'hfe);
        settle();
        chk("tree output", 9'h000, {8'h00, tree_test_on});
        host.wr(`MVOR_OFS_SCRATCH, 8'ha5);
        host.wr(8'h30, 8'h5a);
        chk_rd(`MVOR_OFS_SCRATCH, 8'ha5);
        chk_rd(`MVOR_OFS_TREE, 8'h00);
        chk_rd(8'h30, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            host.wr(`MVOR_OFS_DIODE, 8'hf0 | (8'h01 << i));
            settle();
            chk("diode select", 9'h001 << i, {5'h00, diode_sel});
            chk_rd(`MVOR_OFS_DIODE, 8'h01 << i);
        end
        $display("test controls done");

        pulse_temp();
        for (int i = 0; i < 4; i++)
        begin
            host.wr(raw_ofs[i], 8'hee);
            host.wr(sm_ofs[i], 8'hee);
            chk_rd(raw_ofs[i], zone_raw_temp[i*8+:8]);
            chk_rd(sm_ofs[i], zone_smoothed_temp[i*8+:8]);
        end
        host.wr(`MVOR_OFS_Z3, 8'hee);
        chk_rd(`MVOR_OFS_Z3, 8'h29);
        zone_diode_fault = 4'b1001;
        pulse_temp();
        for (int i = 0; i < 4; i++)
            chk_rd(raw_ofs[i], zone_diode_fault[i] ? `MVOR_DIODE_FAULT_VAL : zone_raw_temp[i*8+:8]);
        host.wr(`MVOR_OFS_Z4, 8'h3c);
        chk_rd(`MVOR_OFS_Z4, 8'h3c);
        zone4_from_ain8 = 1'b1;
        pulse_temp();
        host.wr(`MVOR_OFS_Z4, 8'h11);
        chk_rd(`MVOR_OFS_Z4, 8'h77);
        smooth_ctrl = 8'h5a;
        settle();
        chk("filter control", 9'h05a, {1'b0, filter_ctrl});
        $display("test temperatures done");

        out1_bind = 4'b0101;
        out2_bind = 4'b1010;
        settle();
        chk("duty out1", 9'h0a3, fan_out1_duty);
        chk("duty out2", 9'h100, fan_out2_duty);
        chk_rd(`MVOR_OFS_DUTY1, 8'h51);
        chk_rd(`MVOR_OFS_DUTY2, 8'h80);
        host.wr(`MVOR_OFS_OVR1_HIGH, 8'h7f);
        host.wr(`MVOR_OFS_OVR1_LOW, 8'hff);
        settle();
        chk("override duty", 9'h0ff, fan_out1_duty);
        chk_rd(`MVOR_OFS_OVR1_LOW, 8'hc0);
        chk_rd(`MVOR_OFS_OVR1_HIGH, 8'h7f);
        chk_rd(`MVOR_OFS_DUTY1, 8'h7f);
        host.wr(`MVOR_OFS_OVR1_HIGH, 8'h10);
        host.wr(`MVOR_OFS_OVR1_LOW, 8'h40);
        settle();
        chk("override below sources", 9'h020, fan_out1_duty);
        full_duty_force = 1'b1;
        settle();
        chk("forced out1", `MVOR_DUTY_FULL, fan_out1_duty);
        chk("forced out2", `MVOR_DUTY_FULL, fan_out2_duty);
        full_duty_force = 1'b0;
        host.wr(`MVOR_OFS_OVR1_LOW, 8'h00);
        settle();
        chk("override released", 9'h0a3, fan_out1_duty);
        $display("test duty done");

        // A reset in mid-run must clear what the host has programmed.
        host.wr(`MVOR_OFS_SCRATCH, 8'h3c);
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk_rd(`MVOR_OFS_SCRATCH, 8'h00);
        chk_rd(`MVOR_OFS_DIODE, 8'h00);
        chk_rd(`MVOR_OFS_Z4, 8'h00);
        chk("diode select after reset", 9'h000, {5'h00, diode_sel});
        $display("test second reset done");
        finish_test();
    end
endmodule : monitor_value_override_regs_tb_top
`default_nettype wire
